// ==== verilog/sbc_spi_pkg.sv ====
// Purpose: shared constants for the 16-bit command frame link
// Assumes: msb first, mode 0 (sample on rising, shift on falling)
// Notes: register contents are stand-ins, no real map
package sbc_spi_pkg;
    localparam int FRAME_BITS = 16;
    localparam int OP_HI_POS = 15;
    localparam int OP_LO_POS = 14;
    localparam int ADDR_MSB = 13;
    localparam int ADDR_LSB = 9;
    localparam int PAR_POS = 8;
    localparam int DATA_MSB = 7;
    localparam int ADDR_W = 5;
    localparam int NUM_REGS = 32;
    localparam logic [1:0] OP_READ = 2'h0;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_RSVD = 2'h2;
    localparam logic [1:0] OP_FLAG = 2'h3;
    localparam logic [4:0] FLAG_FIRST = 5'h0F;
    localparam logic [4:0] LIVE_FIRST = 5'h10;
    localparam logic [4:0] LIVE_LAST = 5'h13;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam int CLK_PERIOD_PS = 4000;
    localparam int CS_LOW_PS = 5500000;
    // least time, round up
    localparam int CS_LOW_CYCLES = (CS_LOW_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int LEAD_PS = 550000;
    localparam int LEAD_CYCLES = (LEAD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int HALF_SCK_CYCLES = 16;
endpackage

// ==== verilog/sbc_spi_if.sv ====
// Purpose: link wires between controller and device
// Assumes: miso_oe_b low means the device drives miso
// Notes: idle level of miso is one
interface sbc_spi_if;
    logic sclk;
    logic cs_b;
    logic mosi;
    logic miso_o;
    logic miso_oe_b;
    logic miso;
    assign miso = miso_oe_b ? 1'b1 : miso_o;
    modport device (input sclk, input cs_b, input mosi, output miso_o, output miso_oe_b);
    modport host (output sclk, output cs_b, output mosi, input miso);
endinterface

// ==== verilog/sync2.sv ====
// Purpose: two-stage synchroniser for one level
// Assumes: asynchronous input
// Notes: first stage read only by the second
module sync2 (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic d,
    output logic q
);
    logic meta_reg;
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            meta_reg <= 1'b1;
            q <= 1'b1;
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule

// ==== verilog/sbc_spi_device.sv ====
// Purpose: frame decoder of the device end, sampled by the fast clock
// Assumes: sclk idles low, data sampled on rising, shifted on falling
// Notes: missed write completes on the next frame via held pending slot
//
// Behaviour
// - one 16-bit frame per select, msb first
// - bits 15:14 pick read, write, reserved, flag
// - bits 13:9 address the register
// - write bit 8 is optional parity
// - master sets bit 8 on reads
// - write bit 8 high means parity one
// - bits 7:0 are write data
// - status byte out on bits 15:8
// - low byte: extended status, register, flags
// - no daisy chain pass-through
// - master holds select over 5.5 us
// - master follows writes with a read
// - completing read preferably device id read
// - missed write finishes on next frame
// - only writes may be deferred
// - read-back returns stored register value
// - live block state merged on read-back
// - flag registers answer flag reads
// - write answers extended status, read register
module sbc_spi_device (
    input wire logic clock,
    input wire logic rst_b,
    sbc_spi_if.device link,
    input wire logic [7:0] fixed_status_byte,
    input wire logic [7:0] ext_status,
    input wire logic [31:0] live_state,
    input wire logic [63:0] flag_bits,
    input wire logic parity_enable,
    input wire logic miss_write,
    output logic [4:0] upd_addr,
    output logic [7:0] upd_data,
    output logic upd_strobe,
    output logic parity_error
);
    typedef struct packed {
        logic sclk_d;
        logic cs_d;
        logic [15:0] rx;
        logic [4:0] cnt;
        logic [15:0] tx;
        logic miso;
        logic oe_b;
        logic pend;
        logic [4:0] pend_addr;
        logic [7:0] pend_data;
        logic [4:0] upd_addr;
        logic [7:0] upd_data;
        logic upd_strobe;
        logic par_err;
    } state_s;

    state_s s_reg, s_next;
    logic [7:0] regs [sbc_spi_pkg::NUM_REGS];
    logic sclk_s, cs_s, mosi_s;
    logic wr_en;
    logic [4:0] wr_addr;
    logic [7:0] wr_data;

    sync2 u_sclk (
        .clock(clock),
        .rst_b(rst_b),
        .d(link.sclk),
        .q(sclk_s)
    );
    sync2 u_cs (
        .clock(clock),
        .rst_b(rst_b),
        .d(link.cs_b),
        .q(cs_s)
    );
    sync2 u_mosi (
        .clock(clock),
        .rst_b(rst_b),
        .d(link.mosi),
        .q(mosi_s)
    );

    function automatic logic [4:0] frame_addr(input logic [15:0] w);
        return w[sbc_spi_pkg::ADDR_MSB:sbc_spi_pkg::ADDR_LSB];
    endfunction

    function automatic logic [7:0] frame_data(input logic [15:0] w);
        return w[sbc_spi_pkg::DATA_MSB:0];
    endfunction

    function automatic logic level_edge(input logic now, input logic was, input logic to);
        return (now == to) && (was != to);
    endfunction

    function automatic logic [7:0] answer_byte(input logic [1:0] op, input logic [4:0] a);
        logic [7:0] v;
        v = regs[a];
        if (op == sbc_spi_pkg::OP_WRITE) begin
            v = ext_status;
        end else if (op == sbc_spi_pkg::OP_FLAG) begin
            v = (a >= sbc_spi_pkg::FLAG_FIRST) ? flag_bits[8*(a[2:0])+:8] : 8'h00;
        end else if (a >= sbc_spi_pkg::LIVE_FIRST && a <= sbc_spi_pkg::LIVE_LAST) begin
            v = v | live_state[8*(a[1:0])+:8];
        end
        return v;
    endfunction

    always_comb begin
        logic rise, fall, cs_fall, cs_rise, par_ok;
        logic [1:0] op;
        s_next = s_reg;
        rise = level_edge(sclk_s, s_reg.sclk_d, 1'b1);
        fall = level_edge(sclk_s, s_reg.sclk_d, 1'b0);
        cs_fall = level_edge(cs_s, s_reg.cs_d, 1'b0);
        cs_rise = level_edge(cs_s, s_reg.cs_d, 1'b1);
        op = s_reg.rx[sbc_spi_pkg::OP_HI_POS:sbc_spi_pkg::OP_LO_POS];
        par_ok = (^s_reg.rx) == 1'b1;
        wr_en = 1'b0;
        wr_addr = s_reg.pend_addr;
        wr_data = s_reg.pend_data;
        s_next.sclk_d = sclk_s;
        s_next.cs_d = cs_s;
        s_next.upd_strobe = 1'b0;
        s_next.par_err = 1'b0;
        if (cs_fall) begin
            s_next.cnt = 5'h00;
            s_next.tx = {fixed_status_byte, 8'h00};
            s_next.miso = fixed_status_byte[7];
            s_next.oe_b = 1'b0;
            if (s_reg.pend) begin
                wr_en = 1'b1;
                s_next.pend = 1'b0;
            end
        end else if (!cs_s && rise) begin
            s_next.rx = {s_reg.rx[14:0], mosi_s};
            if (s_reg.cnt != 5'h1F) begin
                s_next.cnt = s_reg.cnt + 5'h01;
            end
            if (s_reg.cnt == 5'(sbc_spi_pkg::FRAME_BITS - 1 - sbc_spi_pkg::ADDR_LSB)) begin
                // six shifts done, so the low byte belongs at 13:6
                s_next.tx[13:6] = answer_byte(s_reg.rx[5:4], {s_reg.rx[3:0], mosi_s});
            end
        end else if (!cs_s && fall) begin
            s_next.tx = {s_reg.tx[14:0], 1'b0};
            s_next.miso = s_reg.tx[14];
        end
        if (cs_rise) begin
            s_next.oe_b = 1'b1;
            s_next.miso = 1'b1;
            if (s_reg.cnt == 5'(sbc_spi_pkg::FRAME_BITS) && op == sbc_spi_pkg::OP_WRITE) begin
                if (parity_enable && !par_ok) begin
                    s_next.par_err = 1'b1;
                end else if (miss_write) begin
                    s_next.pend = 1'b1;
                    s_next.pend_addr = frame_addr(s_reg.rx);
                    s_next.pend_data = frame_data(s_reg.rx);
                end else begin
                    wr_en = 1'b1;
                    wr_addr = frame_addr(s_reg.rx);
                    wr_data = frame_data(s_reg.rx);
                end
            end
        end
        if (wr_en) begin
            s_next.upd_strobe = 1'b1;
            s_next.upd_addr = wr_addr;
            s_next.upd_data = wr_data;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            s_reg <= '{
                // synchroniser resets high, so must the delayed copy
                sclk_d: 1'b1,
                cs_d: 1'b1,
                rx: 16'h0000,
                cnt: 5'h00,
                tx: 16'h0000,
                miso: 1'b1,
                oe_b: 1'b1,
                pend: 1'b0,
                pend_addr: 5'h00,
                pend_data: 8'h00,
                upd_addr: 5'h00,
                upd_data: 8'h00,
                upd_strobe: 1'b0,
                par_err: 1'b0
            };
            for (int i = 0; i < sbc_spi_pkg::NUM_REGS; i++) begin
                regs[i] <= sbc_spi_pkg::REG_RESET;
            end
        end else begin
            s_reg <= s_next;
            if (wr_en) begin
                regs[wr_addr] <= wr_data;
            end
        end
    end

    assign link.miso_o = s_reg.miso;
    assign link.miso_oe_b = s_reg.oe_b;
    assign upd_addr = s_reg.upd_addr;
    assign upd_data = s_reg.upd_data;
    assign upd_strobe = s_reg.upd_strobe;
    assign parity_error = s_reg.par_err;
endmodule

// ==== verilog/sbc_spi_host.sv ====
// Purpose: master end, sends one command word per request
// Assumes: software port, read data one cycle after the read strobe
// Notes: 0x0 command (write starts frame), 0x1 status/answer
module sbc_spi_host (
    input wire logic clock,
    input wire logic rst_b,
    sbc_spi_if.host link,
    input wire logic [3:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [15:0] rdata
);
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_LEAD = 2'b01,
        ST_SHIFT = 2'b10,
        ST_HOLD = 2'b11
    } phase_e;
    typedef struct packed {
        phase_e st;
        logic [15:0] tx;
        logic [15:0] rx;
        logic [15:0] ans;
        logic [10:0] tmr;
        logic [4:0] bits;
        logic sclk;
        logic cs_b;
        logic mosi;
        logic [15:0] rdata;
    } state_s;
    state_s s_reg, s_next;
    logic miso_s;
    sync2 u_miso (.clock(clock), .rst_b(rst_b), .d(link.miso), .q(miso_s));

    always_comb begin
        s_next = s_reg;
        s_next.rdata = 16'h0000;
        if (rd && addr == 4'h1) begin
            s_next.rdata = s_reg.ans;
        end else if (rd && addr == 4'h2) begin
            s_next.rdata = {15'h0000, s_reg.st != ST_IDLE};
        end
        if (s_reg.tmr != 11'h000) begin
            s_next.tmr = s_reg.tmr - 11'h001;
        end
        unique case (s_reg.st)
            ST_IDLE: begin
                if (wr && addr == 4'h0) begin
                    s_next.tx = wdata;
                    s_next.cs_b = 1'b0;
                    s_next.tmr = 11'(sbc_spi_pkg::CS_LOW_CYCLES);
                    s_next.st = ST_LEAD;
                end
            end
            ST_LEAD: begin
                if (s_reg.tmr <= 11'(sbc_spi_pkg::CS_LOW_CYCLES - sbc_spi_pkg::LEAD_CYCLES)) begin
                    s_next.mosi = s_reg.tx[15];
                    s_next.bits = 5'h00;
                    s_next.tmr[4:0] = 5'(sbc_spi_pkg::HALF_SCK_CYCLES);
                    s_next.st = ST_SHIFT;
                end
            end
            ST_SHIFT: begin
                if (s_reg.tmr[4:0] == 5'h00) begin
                    s_next.tmr = 11'(sbc_spi_pkg::HALF_SCK_CYCLES);
                    s_next.sclk = ~s_reg.sclk;
                    if (!s_reg.sclk) begin
                        s_next.rx = {s_reg.rx[14:0], miso_s};
                        s_next.bits = s_reg.bits + 5'h01;
                    end else if (s_reg.bits == 5'(sbc_spi_pkg::FRAME_BITS)) begin
                        s_next.tmr = 11'(sbc_spi_pkg::CS_LOW_CYCLES);
                        s_next.st = ST_HOLD;
                    end else begin
                        s_next.tx = {s_reg.tx[14:0], 1'b0};
                        s_next.mosi = s_reg.tx[14];
                    end
                end
            end
            ST_HOLD: begin
                // generous hold keeps select low past the minimum
                if (s_reg.tmr == 11'h000) begin
                    s_next.cs_b = 1'b1;
                    s_next.ans = s_reg.rx;
                    s_next.st = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            s_reg <= '{st: ST_IDLE, tx: 16'h0000, rx: 16'h0000, ans: 16'h0000, tmr: 11'h000,
                       bits: 5'h00, sclk: 1'b0, cs_b: 1'b1, mosi: 1'b0, rdata: 16'h0000};
        end else begin
            s_reg <= s_next;
        end
    end

    assign link.sclk = s_reg.sclk;
    assign link.cs_b = s_reg.cs_b;
    assign link.mosi = s_reg.mosi;
    assign rdata = s_reg.rdata;
endmodule

// ==== tb/sbc_spi_frame_decoder_properties.sv ====
// Purpose: wire-level checks of the command frame link
// Assumes: one clock domain, sclk and cs_b sampled by clock
// Notes: counters clear while select is high, so each frame starts from zero
module sbc_spi_frame_decoder_properties (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic sclk,
    input wire logic cs_b,
    input wire logic mosi,
    input wire logic miso,
    input wire logic miso_oe_b
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [4:0] edge_reg;
    logic [11:0] low_reg;
    // frame stays below 4096 cycles, so no saturation needed
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            edge_reg <= 5'h00;
            low_reg <= 12'h000;
        end else if (cs_b) begin
            edge_reg <= 5'h00;
            low_reg <= 12'h000;
        end else begin
            edge_reg <= edge_reg + 5'(($rose(sclk)) ? 1 : 0);
            low_reg <= low_reg + 12'h001;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    sequence frame_open;
        $fell(cs_b);
    endsequence
    sequence frame_close;
        $rose(cs_b);
    endsequence
    sclk_idle_low_a: assert property (cs_b |-> !sclk)
        else $error("sclk high while deselected");
    sixteen_clocks_a: assert property (frame_close |-> edge_reg == 5'h10)
        else $error("frame closed without sixteen clocks");
    select_low_a: assert property (frame_close |-> low_reg >= sbc_spi_pkg::CS_LOW_CYCLES)
        else $error("select low too short");
    lead_time_a: assert property (($rose(sclk) && edge_reg == 5'h00) |->
        low_reg >= sbc_spi_pkg::LEAD_CYCLES)
        else $error("first clock too soon after select");
    lead_quiet_a: assert property (frame_open |-> (!sclk)[*8])
        else $error("clock moved right after select");
    mosi_stable_a: assert property ((sclk && $past(sclk)) |-> $stable(mosi))
        else $error("mosi moved while sclk high");
    miso_drive_a: assert property (frame_open |-> ##[1:100] !miso_oe_b)
        else $error("device never drove miso");
    miso_release_a: assert property (cs_b[*8] |-> miso_oe_b)
        else $error("miso driven while deselected");
endmodule

// ==== tb/sbc_spi_frame_decoder_tb_top.sv ====
// Purpose: end-to-end bench, host and device joined over the link
// Assumes: host port 0 command, 1 answer, 2 busy in bit 0
// Notes: frames run ~2k cycles, every wait is bounded
module sbc_spi_frame_decoder_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [15:0] rdata;
    logic [7:0] fixed_status_byte = 8'hA5;
    logic [7:0] ext_status = 8'h5A;
    logic [31:0] live_state = 32'h0000_0003;
    logic [63:0] flag_bits = 64'h0000_0000_0000_003C;
    logic parity_enable = 1'b0;
    logic miss_write = 1'b0;
    logic [4:0] upd_addr;
    logic [7:0] upd_data;
    logic upd_strobe;
    logic parity_error;
    logic [15:0] mosi_sh = 16'h0000;
    logic [15:0] miso_sh = 16'h0000;
    int strobes = 0;
    int perrs = 0;
    int errors = 0;
    int samples_checked = 0;
    sbc_spi_if link();
    sbc_spi_device u_sbc_spi_device (.clock(clock), .rst_b(rst_b), .link(link.device),
        .fixed_status_byte(fixed_status_byte), .ext_status(ext_status), .live_state(live_state),
        .flag_bits(flag_bits), .parity_enable(parity_enable), .miss_write(miss_write),
        .upd_addr(upd_addr), .upd_data(upd_data), .upd_strobe(upd_strobe),
        .parity_error(parity_error));
    sbc_spi_host u_sbc_spi_host (.clock(clock), .rst_b(rst_b), .link(link.host), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
    sbc_spi_frame_decoder_properties u_props (.clock(clock), .rst_b(rst_b), .sclk(link.sclk),
        .cs_b(link.cs_b), .mosi(link.mosi), .miso(link.miso), .miso_oe_b(link.miso_oe_b));
    always #2 clock = ~clock;
    always @(posedge link.sclk) begin
        mosi_sh <= {mosi_sh[14:0], link.mosi};
        miso_sh <= {miso_sh[14:0], link.miso};
    end
    always @(posedge clock) begin
        strobes <= strobes + int'(upd_strobe === 1'b1);
        perrs <= perrs + int'(parity_error === 1'b1);
    end
    task automatic final_report();
        $display("checks %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic bus_wr(input logic [3:0] a, input logic [15:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
    endtask
    task automatic bus_rd(input logic [3:0] a, output logic [15:0] d);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        #1 d = rdata;
        @(posedge clock);
    endtask
    task automatic frame(input logic [15:0] cmd, output logic [15:0] ans);
        logic [15:0] st;
        int n;
        bus_wr(4'h0, cmd);
        st = 16'h0001;
        for (n = 0; n < 2000 && st[0] !== 1'b0; n++) bus_rd(4'h2, st);
        if (st[0] !== 1'b0) begin
            errors++;
            final_report();
        end
        // device acts a few cycles after the synchronised release
        repeat (8) @(posedge clock);
        bus_rd(4'h1, ans);
        check("mosi word", mosi_sh, cmd);
        check("miso word", miso_sh, ans);
        check("status byte", {8'h00, ans[15:8]}, {8'h00, fixed_status_byte});
    endtask
    task automatic s_write_read();
        logic [15:0] a;
        int s0;
        s0 = strobes;
        frame(16'h60C0, a);
        check("write answer", {8'h00, a[7:0]}, {8'h00, ext_status});
        check("write strobe", 16'(strobes - s0), 16'h0001);
        check("write target", {3'h0, upd_addr, upd_data}, 16'h10C0);
        frame(16'h2580, a);
        check("id read", {8'h00, a[7:0]}, 16'h0000);
        frame(16'h2100, a);
        check("read back", {8'h00, a[7:0]}, 16'h00C3);
    endtask
    task automatic s_ops();
        logic [15:0] a;
        int s0;
        s0 = strobes;
        frame(16'hA1FF, a);
        frame(16'hE100, a);
        check("flag read", {8'h00, a[7:0]}, 16'h003C);
        frame(16'hC300, a);
        check("flag none", {8'h00, a[7:0]}, 16'h0000);
        frame(16'h2100, a);
        check("reserved kept", {8'h00, a[7:0]}, 16'h00C3);
        check("no strobe", 16'(strobes - s0), 16'h0000);
    endtask
    task automatic s_parity();
        logic [15:0] a;
        int s0;
        int p0;
        parity_enable <= 1'b1;
        s0 = strobes;
        p0 = perrs;
        frame(16'h60C0, a);
        check("parity error", 16'(perrs - p0), 16'h0001);
        frame(16'h61A0, a);
        check("parity write", 16'(strobes - s0), 16'h0001);
        frame(16'h2100, a);
        check("parity data", {8'h00, a[7:0]}, 16'h00A3);
        parity_enable <= 1'b0;
    endtask
    task automatic s_miss();
        logic [15:0] a;
        int s0;
        miss_write <= 1'b1;
        s0 = strobes;
        frame(16'h66C0, a);
        check("write deferred", 16'(strobes - s0), 16'h0000);
        miss_write <= 1'b0;
        frame(16'h2700, a);
        check("write completed", 16'(strobes - s0), 16'h0001);
        check("late target", {3'h0, upd_addr, upd_data}, 16'h13C0);
        check("read own frame", {8'h00, a[7:0]}, 16'h00C0);
    endtask
    initial begin
        repeat (16) @(posedge clock);
        rst_b <= 1'b1;
        @(posedge clock);
        s_write_read();
        s_ops();
        s_parity();
        s_miss();
        final_report();
    end
endmodule
